// [logic/timer16_capture_compare_units.sv]
// How it works
// [R01] A qualified capture edge copies the whole 16-bit counter into the capture value.
// [R02] The capture flag rises in the same cycle the capture value is loaded.
// [R03] Capture flag raises its interrupt when enabled; service ack or write-one clears it.
// [R04] Capture low read copies its high byte to the shared latch; high read returns latch.
// [R05] Capture value is writable only in capture-TOP modes, high byte first.
// [R06] Comparator capture select swaps the trigger from the pin to the comparator output.
// [R07] Changing the trigger source may capture; software clears the flag afterwards.
// [R08] With filtering on, output changes only after four equal consecutive samples.
// [R09] Filter enable sits in control B, runs on the system clock, adds four cycles.
// [R10] Edge detector events are masked in capture-TOP modes, active otherwise; the filter keeps sampling.
// [R11] Levels driven onto the capture pin by the port trigger captures like any other.
// [R12] Every new capture overwrites the capture value, read or not.
// [R13] Each channel compares counter with its value; equality sets its flag on timer tick.
// [R14] Compare flag raises its interrupt when enabled; ack or write-one clears it.
// [R15] Channel A's active compare value is exported as a possible counter TOP.
// [R16] PWM modes double buffer compare values, loaded at TOP or BOTTOM; others bypass.
// [R17] Compare accesses hit the buffer when buffering is on, the active value otherwise.
// [R18] Compare high-byte reads return the register, not the shared latch.
// [R19] Compare high write fills the latch; low write loads all sixteen bits at once.
// [R20] Force strobe in non-PWM modes acts like a match without flag or counter effect.
// [R21] A counter write blocks all compare matches on the next timer tick.
// [R22] Output action bits act immediately; output states survive mode changes.
// [R23] One high-byte latch serves counter, capture and all compare registers.
// [R24] Reset drives every compare output state to zero.
// [R25] Output action zero leaves the compare output unchanged on a match.
// [R26] Edge select chooses rising or falling filtered transitions as capture trigger.
`timescale 1ns/1ps
module timer16_capture_compare_units
  import timer_cc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [15:0] counter_value,
  input wire logic timer_tick,
  input wire logic buffer_update,
  input wire logic at_bottom,
  input wire logic capture_pin,
  input wire logic comparator_output,
  input wire logic capture_irq_ack,
  input wire logic [CH_COUNT-1:0] compare_irq_ack,
  output logic capture_irq,
  output logic [CH_COUNT-1:0] compare_irq,
  output logic [CH_COUNT-1:0] compare_output,
  output logic counter_write,
  output logic [15:0] counter_write_data,
  output logic [MODE_W-1:0] waveform_mode_sel,
  output logic [15:0] compare_a_value,
  output logic [15:0] capture_value
);

  logic [7:0] high_latch;
  logic [7:0] ctrl_a;
  logic [7:0] timer_control_b;
  logic [7:0] comparator_ctrl_status;
  logic [7:0] irq_enable;
  logic capture_flag;
  logic [CH_COUNT-1:0] compare_flag;
  logic [15:0] compare_buf [CH_COUNT];
  logic [15:0] compare_act [CH_COUNT];
  logic match_block;
  logic [7:0] read_byte;

  capture_if cap ();

  capture_conditioner u_capture_conditioner (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .cap(cap.conditioner)
  );

  // Bus decode: access takes effect at the edge where waitrequest is low
  wire bus_req = avs_read | avs_write;
  wire accept = bus_req & ~avs_waitrequest;
  wire wr_acc = accept & avs_write & avs_byteenable[0];
  wire rd_acc = accept & avs_read;
  wire [7:0] wbyte = avs_writedata[7:0];
  wire [15:0] wword = {high_latch, wbyte};

  // Mode decode shared by capture and compare logic
  wire [MODE_W-1:0] mode = timer_control_b[CTRL_B_MODE_LSB +: MODE_W];
  wire pwm_mode = mode_is_pwm(mode);
  wire cap_top_mode = mode_cap_top(mode);

  wire wr_cnt_lo = wr_acc && avs_address == ADDR_CNT_LO;
  wire wr_cap_lo = wr_acc && avs_address == ADDR_CAP_LO;
  wire rd_cnt_lo = rd_acc && avs_address == ADDR_CNT_LO;
  wire rd_cap_lo = rd_acc && avs_address == ADDR_CAP_LO;
  wire wr_ctrl_c = wr_acc && avs_address == ADDR_CTRL_C;
  wire wr_flags = wr_acc && avs_address == ADDR_FLAGS;
  wire wr_any_hi = wr_acc && (avs_address == ADDR_CNT_HI || avs_address == ADDR_CAP_HI ||
                              cmp_hi_hit(avs_address));

  // True when the address is any compare high byte
  function automatic logic cmp_hi_hit(input logic [7:0] addr);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < CH_COUNT; k++) begin
      if (addr == 8'(ADDR_CMP_LO_BASE + ADDR_CMP_HI_OFS + 8'(k) * ADDR_CMP_STRIDE)) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // Capture input wiring
  assign cap.pin = capture_pin; // R11
  assign cap.comparator = comparator_output;
  assign cap.use_comparator = comparator_ctrl_status[COMP_SEL_BIT]; // R06 R07
  assign cap.filter_en = timer_control_b[CTRL_B_FILTER_BIT]; // R09
  assign cap.rising = timer_control_b[CTRL_B_EDGE_BIT]; // R26
  assign cap.enable = ~cap_top_mode; // R10

  // Waitrequest: one wait state, then released for exactly one edge
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
    end
  end

  // Read data sampled in the wait cycle, stands through the accept edge
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= '0;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= {24'h000000, read_byte};
    end
  end

  // Shared high-byte latch
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      high_latch <= RESET_BYTE;
    end else if (wr_any_hi) begin
      high_latch <= wbyte; // R19 R23
    end else if (rd_cnt_lo) begin
      high_latch <= counter_value[15:8]; // R23
    end else if (rd_cap_lo) begin
      high_latch <= capture_value[15:8]; // R04
    end
  end

  // Plain control registers; output actions act at once, not buffered
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_a <= RESET_BYTE;
      timer_control_b <= RESET_BYTE;
      comparator_ctrl_status <= RESET_BYTE;
      irq_enable <= RESET_BYTE;
    end else if (wr_acc) begin
      if (avs_address == ADDR_CTRL_A) ctrl_a <= wbyte; // R22
      if (avs_address == ADDR_CTRL_B) timer_control_b <= wbyte; // R09
      if (avs_address == ADDR_CMP_STATUS) comparator_ctrl_status <= wbyte;
      if (avs_address == ADDR_IRQ_EN) irq_enable <= wbyte;
    end
  end

  assign waveform_mode_sel = mode;

  // Counter write goes out as a pulse; the counter unit owns the value
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      counter_write <= 1'b0;
      counter_write_data <= RESET_WORD;
    end else begin
      counter_write <= wr_cnt_lo;
      if (wr_cnt_lo) counter_write_data <= wword;
    end
  end

  // Block matches on the first tick after a counter write, even when stopped
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      match_block <= 1'b0;
    end else if (wr_cnt_lo) begin
      match_block <= 1'b1; // R21
    end else if (timer_tick) begin
      match_block <= 1'b0;
    end
  end

  // Capture value: every event overwrites, writes allowed only in capture-TOP modes
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      capture_value <= RESET_WORD;
    end else if (cap.event_hit) begin
      capture_value <= counter_value; // R01 R12
    end else if (wr_cap_lo && cap_top_mode) begin
      capture_value <= wword; // R05
    end
  end

  // Capture flag: a set in the same cycle as a clear wins
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      capture_flag <= 1'b0;
    end else if (cap.event_hit) begin
      capture_flag <= 1'b1; // R02
    end else if (capture_irq_ack || (wr_flags && wbyte[FLAG_CAPTURE_BIT])) begin
      capture_flag <= 1'b0; // R03 R07
    end
  end

  // Interrupt requests, registered one cycle behind their flags
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      capture_irq <= 1'b0;
      compare_irq <= '0;
    end else begin
      capture_irq <= capture_flag & irq_enable[FLAG_CAPTURE_BIT]; // R03
      compare_irq <= compare_flag & irq_enable[FLAG_CMP_LSB +: CH_COUNT]; // R14
    end
  end

  // Compare channels
  genvar i;
  generate
    for (i = 0; i < CH_COUNT; i++) begin : g_ch
      localparam logic [7:0] LO_ADDR = 8'(ADDR_CMP_LO_BASE + 8'(i) * ADDR_CMP_STRIDE);
      wire wr_lo = wr_acc && avs_address == LO_ADDR;
      wire [1:0] action = ctrl_a[i*ACT_W +: ACT_W];
      wire hit = timer_tick && !match_block && counter_value == compare_act[i]; // R13 R21
      wire force_hit = wr_ctrl_c && wbyte[FORCE_LSB+i] && !pwm_mode; // R20
      wire clr = compare_irq_ack[i] || (wr_flags && wbyte[FLAG_CMP_LSB+i]);
      logic next_out;

      // Output action: non-PWM on match or force; PWM sets or clears at match and bottom
      always_comb begin
        next_out = compare_output[i];
        if (!pwm_mode && (hit || force_hit)) begin
          case (action)
            ACT_TOGGLE: next_out = ~compare_output[i];
            ACT_CLEAR: next_out = 1'b0;
            ACT_SET: next_out = 1'b1;
            default: next_out = compare_output[i]; // R25
          endcase
        end else if (pwm_mode && hit) begin
          case (action)
            ACT_CLEAR: next_out = 1'b0;
            ACT_SET: next_out = 1'b1;
            default: next_out = compare_output[i]; // R25
          endcase
        end else if (pwm_mode && timer_tick && at_bottom) begin
          case (action)
            ACT_CLEAR: next_out = 1'b1;
            ACT_SET: next_out = 1'b0;
            default: next_out = compare_output[i];
          endcase
        end
      end

      // Output state is untouched by mode changes, only by matches, force strobes and PWM bottom ticks
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          compare_output[i] <= 1'b0; // R24
        end else begin
          compare_output[i] <= next_out; // R22
        end
      end

      // Buffer takes every CPU write; active copy loads on update strobe in PWM modes, on the write otherwise
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          compare_buf[i] <= RESET_WORD;
          compare_act[i] <= RESET_WORD;
        end else begin
          if (wr_lo) compare_buf[i] <= wword; // R17 R19
          if (wr_lo && !pwm_mode) begin
            compare_act[i] <= wword; // R16 R17
          end else if (pwm_mode && buffer_update) begin
            compare_act[i] <= compare_buf[i]; // R16
          end
        end
      end

      // Flag sets on a real match only; set beats a same-cycle clear
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          compare_flag[i] <= 1'b0;
        end else if (hit) begin
          compare_flag[i] <= 1'b1; // R13
        end else if (clr) begin
          compare_flag[i] <= 1'b0; // R14
        end
      end
    end
  endgenerate

  assign compare_a_value = compare_act[0]; // R15

  // Read selection; unmapped addresses read zero
  always_comb begin
    read_byte = RESET_BYTE;
    case (avs_address)
      ADDR_CTRL_A: read_byte = ctrl_a;
      ADDR_CTRL_B: read_byte = timer_control_b;
      ADDR_CNT_LO: read_byte = counter_value[7:0];
      ADDR_CNT_HI: read_byte = high_latch;
      ADDR_CAP_LO: read_byte = capture_value[7:0];
      ADDR_CAP_HI: read_byte = high_latch; // R04
      ADDR_FLAGS: read_byte = 8'({capture_flag, 1'b0, compare_flag, 1'b0});
      ADDR_IRQ_EN: read_byte = irq_enable;
      ADDR_CMP_STATUS: read_byte = comparator_ctrl_status;
      default: read_byte = RESET_BYTE;
    endcase
    for (int k = 0; k < CH_COUNT; k++) begin
      if (avs_address == 8'(ADDR_CMP_LO_BASE + 8'(k) * ADDR_CMP_STRIDE)) begin
        read_byte = pwm_mode ? compare_buf[k][7:0] : compare_act[k][7:0]; // R17
      end
      if (avs_address == 8'(ADDR_CMP_LO_BASE + ADDR_CMP_HI_OFS + 8'(k) * ADDR_CMP_STRIDE)) begin
        read_byte = pwm_mode ? compare_buf[k][15:8] : compare_act[k][15:8]; // R18
      end
    end
  end

endmodule // timer16_capture_compare_units

// [logic/timer_cc_pkg.sv]
package timer_cc_pkg;

  // Channel count and capture filter depth
  localparam int CH_COUNT = 3;
  localparam int FILTER_SAMPLES = 4;
  localparam int SYNC_STAGES = 2;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [7:0] ADDR_CTRL_A = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B = 8'h04;
  localparam logic [7:0] ADDR_CTRL_C = 8'h08;
  localparam logic [7:0] ADDR_CNT_LO = 8'h0C;
  localparam logic [7:0] ADDR_CNT_HI = 8'h10;
  localparam logic [7:0] ADDR_CAP_LO = 8'h14;
  localparam logic [7:0] ADDR_CAP_HI = 8'h18;
  localparam logic [7:0] ADDR_CMP_LO_BASE = 8'h1C;
  localparam logic [7:0] ADDR_CMP_HI_OFS = 8'h04;
  localparam logic [7:0] ADDR_CMP_STRIDE = 8'h08;
  localparam logic [7:0] ADDR_FLAGS = 8'h34;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h38;
  localparam logic [7:0] ADDR_CMP_STATUS = 8'h3C;

  // Field positions
  localparam int CTRL_B_FILTER_BIT = 7;
  localparam int CTRL_B_EDGE_BIT = 6;
  localparam int CTRL_B_MODE_LSB = 0;
  localparam int MODE_W = 4;
  localparam int ACT_W = 2;
  localparam int FORCE_LSB = 5;
  localparam int FLAG_CAPTURE_BIT = 5;
  localparam int FLAG_CMP_LSB = 1;
  localparam int COMP_SEL_BIT = 2;

  // Reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;

  // Output action encodings
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  // Waveform modes without double buffering, and those with capture-defined TOP
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_CTC_CMP = 4'h4;
  localparam logic [3:0] MODE_CTC_CAP = 4'hC;
  localparam logic [3:0] MODE_RESERVED = 4'hD;
  localparam logic [3:0] MODE_PFC_CAP = 4'h8;
  localparam logic [3:0] MODE_PC_CAP = 4'hA;
  localparam logic [3:0] MODE_FAST_CAP = 4'hE;

  // Twelve PWM modes: everything but normal, the two clear-on-match modes and reserved
  function automatic logic mode_is_pwm(input logic [3:0] mode);
    return !(mode == MODE_NORMAL || mode == MODE_CTC_CMP ||
             mode == MODE_CTC_CAP || mode == MODE_RESERVED);
  endfunction

  function automatic logic mode_cap_top(input logic [3:0] mode);
    return mode == MODE_PFC_CAP || mode == MODE_PC_CAP ||
           mode == MODE_CTC_CAP || mode == MODE_FAST_CAP;
  endfunction

endpackage

// [logic/capture_if.sv]
`timescale 1ns/1ps
interface capture_if;
  logic pin;
  logic comparator;
  logic use_comparator;
  logic filter_en;
  logic rising;
  logic enable;
  logic event_hit;

  modport conditioner (
    input pin,
    input comparator,
    input use_comparator,
    input filter_en,
    input rising,
    input enable,
    output event_hit
  );

  modport owner (
    output pin,
    output comparator,
    output use_comparator,
    output filter_en,
    output rising,
    output enable,
    input event_hit
  );
endinterface

// [logic/capture_conditioner.sv]
`timescale 1ns/1ps
module capture_conditioner
  import timer_cc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  capture_if.conditioner cap
);

  logic [SYNC_STAGES-1:0] pin_sync;
  logic [SYNC_STAGES-1:0] cmp_sync;
  logic [FILTER_SAMPLES-1:0] history;
  logic filtered;
  logic filtered_prev;
  logic event_reg;

  // Source select reads only the second synchroniser stage
  wire sample = cap.use_comparator ? cmp_sync[1] : pin_sync[1]; // R06
  wire [FILTER_SAMPLES-1:0] next_history = {history[FILTER_SAMPLES-2:0], sample};
  // Judging the registered samples gives the full four-cycle filter latency
  wire all_high = &history;
  wire all_low = ~|history;
  wire next_filtered = cap.filter_en ? (all_high ? 1'b1 : (all_low ? 1'b0 : filtered))
                                     : sample; // R08
  wire rise = filtered & ~filtered_prev;
  wire fall = ~filtered & filtered_prev;
  wire next_event = cap.enable & (cap.rising ? rise : fall); // R26 R10

  // Two-stage synchronisers for both asynchronous sources
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_sync <= '0;
      cmp_sync <= '0;
    end else begin
      pin_sync <= {pin_sync[0], cap.pin}; // R11
      cmp_sync <= {cmp_sync[0], cap.comparator};
    end
  end

  // Filter and edge detector run on the undivided clock
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      history <= '0;
      filtered <= 1'b0;
      filtered_prev <= 1'b0;
      event_reg <= 1'b0;
    end else begin
      history <= next_history; // R09
      filtered <= next_filtered;
      filtered_prev <= filtered;
      event_reg <= next_event;
    end
  end

  assign cap.event_hit = event_reg;

endmodule // capture_conditioner

// [test/timer_cc_props.sv]
`timescale 1ns/1ps
module timer_cc_props
  import timer_cc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic [15:0] counter_value,
  input wire logic timer_tick,
  input wire logic buffer_update,
  input wire logic [CH_COUNT-1:0] compare_irq,
  input wire logic [CH_COUNT-1:0] compare_output,
  input wire logic counter_write,
  input wire logic [15:0] counter_write_data,
  input wire logic [MODE_W-1:0] waveform_mode_sel,
  input wire logic [15:0] compare_a_value,
  input wire logic [15:0] capture_value
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Accepted byte-enabled write, the only moment a control register may change
  wire wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];

  // Bus handshake
  a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered on the next cycle");
  // Capture, counter write, reset and mode write effects
  a_cap_from_counter: assert property ($changed(capture_value) && !$past(avs_write) |->
    capture_value == $past(counter_value)) else $error("capture value not the counter value");
  a_cnt_write_commit: assert property (wr_ok && avs_address == ADDR_CNT_LO |=>
    counter_write && counter_write_data[7:0] == $past(avs_writedata[7:0]))
    else $error("counter write not committed");
  a_cnt_pulse_single: assert property (counter_write |=> !counter_write)
    else $error("counter write pulse too long");
  a_reset_clears: assert property ($rose(reset_n) |-> compare_output == '0)
    else $error("compare outputs not cleared by reset");
  a_mode_write: assert property (wr_ok && avs_address == ADDR_CTRL_B |=>
    waveform_mode_sel == $past(avs_writedata[3:0])) else $error("mode select not updated");
  // Causes of compare state changes
  a_cmpa_cause: assert property ($changed(compare_a_value) |->
    $past(avs_write) || $past(buffer_update)) else $error("compare A changed without cause");
  a_out_cause: assert property ($changed(compare_output) |-> $past(timer_tick) ||
    $past(timer_tick, 2) || $past(avs_write) || $past(avs_write, 2))
    else $error("compare output changed without cause");
  a_irq_cause: assert property ($rose(compare_irq[0]) |-> $past(timer_tick, 2) ||
    $past(timer_tick, 3) || $past(avs_write) || $past(avs_write, 2))
    else $error("compare irq rose without a tick");

  c_capture: cover property ($changed(capture_value));
  c_cmp_irq: cover property ($rose(compare_irq[0]));
  c_cnt_write: cover property (counter_write);
endmodule // timer_cc_props

bind timer16_capture_compare_units timer_cc_props timer_cc_props_inst (.ref_clk(ref_clk),
  .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .counter_value(counter_value), .timer_tick(timer_tick),
  .buffer_update(buffer_update), .compare_irq(compare_irq), .compare_output(compare_output),
  .counter_write(counter_write), .counter_write_data(counter_write_data),
  .waveform_mode_sel(waveform_mode_sel), .compare_a_value(compare_a_value),
  .capture_value(capture_value));

// [test/capture_source.sv]
`timescale 1ns/1ps
module capture_source (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic want_pin,
  input wire logic want_cmp,
  output logic capture_pin,
  output logic comparator_output
);
  // Port and comparator levels move just after an edge, as on-chip drivers do
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      capture_pin <= 1'b0;
      comparator_output <= 1'b0;
    end else begin
      capture_pin <= want_pin;
      comparator_output <= want_cmp;
    end
  end
endmodule // capture_source

// [test/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import timer_cc_pkg::*;
  localparam logic [7:0] CMPA_HI = ADDR_CMP_LO_BASE + ADDR_CMP_HI_OFS;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0, avs_write = 1'b0, timer_tick = 1'b0, buffer_update = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic at_bottom = 1'b0, want_pin = 1'b0, want_cmp = 1'b0, capture_irq_ack = 1'b0;
  logic [2:0] compare_irq_ack = 3'h0;
  logic [15:0] counter_value = 16'h0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, capture_pin, comparator_output, capture_irq, counter_write, s_cirq;
  logic [2:0] compare_irq, compare_output, s_mirq, s_out;
  logic [15:0] counter_write_data, compare_a_value, capture_value, s_cap, s_cmpa;
  logic [3:0] waveform_mode_sel;
  logic [7:0] rdat;
  int fail_count = 0, cmp_count = 0, cyc = 0;

  timer16_capture_compare_units timer16_capture_compare_units_inst (.ref_clk, .reset_n,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .counter_value, .timer_tick, .buffer_update, .at_bottom, .capture_pin,
    .comparator_output, .capture_irq_ack, .compare_irq_ack, .capture_irq, .compare_irq,
    .compare_output, .counter_write, .counter_write_data, .waveform_mode_sel,
    .compare_a_value, .capture_value);
  capture_source capture_source_inst (.ref_clk, .reset_n, .want_pin, .want_cmp, .capture_pin,
    .comparator_output);

  always #10 ref_clk = ~ref_clk;
  // Outputs are judged from a mid-cycle snapshot, away from the edge race
  always @(negedge ref_clk) begin
    s_cirq = capture_irq;
    s_mirq = compare_irq;
    s_out = compare_output;
    s_cap = capture_value;
    s_cmpa = compare_a_value;
  end
  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 8000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One Avalon access; held until waitrequest is seen low, then released
  task automatic bus(input logic rd, input logic [7:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_read <= rd;
    avs_write <= !rd;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
    rdat = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b0, a, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b1, a, 8'h00);
    chk({8'h00, rdat}, {8'h00, exp});
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic tick();
    timer_tick <= 1'b1;
    @(posedge ref_clk);
    timer_tick <= 1'b0;
    cycles(3);
  endtask
  // Move a capture source and count cycles until the capture value moves (30 means never)
  task automatic src(input logic cmp, input logic v, output int n);
    logic [15:0] old;
    old = s_cap;
    if (cmp) want_cmp <= v;
    else want_pin <= v;
    n = 0;
    while (s_cap === old && n < 30) begin
      @(posedge ref_clk);
      n++;
    end
  endtask

  task automatic t_reset();
    rchk(ADDR_CTRL_B, RESET_BYTE);
    rchk(ADDR_FLAGS, RESET_BYTE);
    rchk(8'h40, 8'h00);
    chk({13'h0, s_out}, RESET_WORD);
  endtask
  task automatic t_capture();
    int n;
    counter_value <= 16'h1234;
    wr(ADDR_CTRL_B, 8'h40);
    wr(ADDR_IRQ_EN, 8'h20);
    src(1'b0, 1'b1, n);
    chk(s_cap, 16'h1234);
    rchk(ADDR_FLAGS, 8'h20);
    chk({15'h0, s_cirq}, 16'h0001);
    counter_value <= 16'hABCD;
    src(1'b0, 1'b0, n);
    chk(s_cap, 16'h1234);
    rchk(ADDR_CAP_LO, 8'h34);
    src(1'b0, 1'b1, n);
    rchk(ADDR_CAP_HI, 8'h12);
    chk(s_cap, 16'hABCD);
    wr(ADDR_FLAGS, 8'h20);
    cycles(2);
    chk({15'h0, s_cirq}, 16'h0000);
  endtask
  task automatic t_comparator();
    int n;
    src(1'b0, 1'b0, n);
    counter_value <= 16'h0BEE;
    wr(ADDR_CMP_STATUS, 8'h04);
    wr(ADDR_FLAGS, 8'h20);
    src(1'b0, 1'b1, n);
    chk(s_cap, 16'hABCD);
    src(1'b1, 1'b1, n);
    chk(s_cap, 16'h0BEE);
    cycles(2);
    chk({15'h0, s_cirq}, 16'h0001);
    capture_irq_ack <= 1'b1;
    @(posedge ref_clk);
    capture_irq_ack <= 1'b0;
    cycles(3);
    chk({15'h0, s_cirq}, 16'h0000);
    wr(ADDR_CMP_STATUS, 8'h00);
    src(1'b1, 1'b0, n);
    wr(ADDR_FLAGS, 8'h20);
    cycles(2);
    chk({15'h0, s_cirq}, 16'h0000);
  endtask
  task automatic t_filter();
    int n, lat0, lat1;
    src(1'b0, 1'b0, n);
    counter_value <= 16'h0111;
    src(1'b0, 1'b1, lat0);
    wr(ADDR_CTRL_B, 8'hC0);
    src(1'b0, 1'b0, n);
    counter_value <= 16'h0222;
    want_pin <= 1'b1;
    cycles(3);
    want_pin <= 1'b0;
    cycles(12);
    chk(s_cap, 16'h0111);
    src(1'b0, 1'b1, lat1);
    chk(s_cap, 16'h0222);
    chk(16'(lat1 - lat0), 16'h0004);
  endtask
  task automatic t_cap_top();
    int n;
    wr(ADDR_CTRL_B, 8'h4C);
    wr(ADDR_CAP_HI, 8'h56);
    wr(ADDR_CAP_LO, 8'h78);
    chk(s_cap, 16'h5678);
    src(1'b0, 1'b0, n);
    src(1'b0, 1'b1, n);
    chk(s_cap, 16'h5678);
    wr(ADDR_CTRL_B, 8'h40);
    wr(ADDR_CAP_HI, 8'h9A);
    wr(ADDR_CAP_LO, 8'hBC);
    chk(s_cap, 16'h5678);
  endtask
  task automatic t_compare();
    wr(ADDR_CTRL_A, {6'h0, ACT_TOGGLE});
    wr(CMPA_HI, 8'h00);
    wr(ADDR_CMP_LO_BASE, 8'h10);
    chk(s_cmpa, 16'h0010);
    rchk(ADDR_CAP_LO, 8'h78);
    rchk(CMPA_HI, 8'h00);
    wr(ADDR_IRQ_EN, 8'h02);
    counter_value <= 16'h0010;
    tick();
    chk({13'h0, s_out}, 16'h0001);
    rchk(ADDR_FLAGS, 8'h22);
    chk({13'h0, s_mirq}, 16'h0001);
    compare_irq_ack <= 3'h1;
    @(posedge ref_clk);
    compare_irq_ack <= 3'h0;
    cycles(3);
    chk({13'h0, s_mirq}, 16'h0000);
    wr(ADDR_CTRL_C, 8'h20);
    chk({13'h0, s_out}, 16'h0000);
    rchk(ADDR_FLAGS, 8'h20);
    wr(ADDR_CNT_HI, 8'h00);
    wr(ADDR_CNT_LO, 8'h10);
    tick();
    rchk(ADDR_FLAGS, 8'h20);
    tick();
    rchk(ADDR_FLAGS, 8'h22);
    wr(ADDR_FLAGS, 8'h02);
    wr(ADDR_CTRL_A, {6'h0, ACT_NONE});
    tick();
    chk({13'h0, s_out}, 16'h0001);
  endtask
  task automatic t_pwm();
    wr(ADDR_CTRL_B, 8'h45);
    wr(CMPA_HI, 8'h00);
    wr(ADDR_CMP_LO_BASE, 8'h30);
    chk(s_cmpa, 16'h0010);
    buffer_update <= 1'b1;
    @(posedge ref_clk);
    buffer_update <= 1'b0;
    cycles(2);
    chk(s_cmpa, 16'h0030);
    wr(ADDR_CTRL_A, {6'h0, ACT_TOGGLE});
    wr(ADDR_CTRL_C, 8'h20);
    chk({13'h0, s_out}, 16'h0001);
    wr(ADDR_CTRL_B, 8'h40);
    chk({13'h0, s_out}, 16'h0001);
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_capture();
    t_comparator();
    t_filter();
    t_cap_top();
    t_compare();
    t_pwm();
    print_verdict();
  end
endmodule // tb_top
